// File: hw/fg_defs.svh
// register offsets, field positions, reset values and timing figures of the gauge
`ifndef FG_DEFS_SVH
`define FG_DEFS_SVH

// ***************************************************************
// register map
// ***************************************************************
`define FG_OFS_CONFIG       8'h01
`define FG_OFS_REL_CAP      8'h02
`define FG_OFS_AUX0         8'h08
`define FG_OFS_AUX1         8'h0A
`define FG_OFS_VOLT         8'h0C
`define FG_OFS_CURR         8'h0E
`define FG_OFS_TEMP         8'h10
`define FG_OFS_LAST_OPEN_CIRCUIT_CAPACITY     8'h16
`define FG_OFS_LEARN_SCALE  8'h17
`define FG_OFS_BIAS         8'h33
`define FG_OFS_INIT_SCALE   8'h7A

// ***************************************************************
// fields and reset values
// ***************************************************************
`define FG_CFG_TEMP_SEL_BIT 0
`define FG_BIAS_RST         8'h00
`define FG_LEARN_SCALE_RST  8'h00
`define FG_INIT_SCALE_RST   8'h00
`define FG_LAST_OPEN_CIRCUIT_CAPACITY_RST     8'h00
`define FG_REL_CAP_MAX      8'hC8
`define FG_RES_POS_MAX      16'h7FFF
`define FG_RES_NEG_MAX      16'h8000
`define FG_OFFSET_SLOT      10'h3FF
// accumulator span in current-result counts per period, and capacity divisor
`define FG_ACC_LIMIT        32'h1FF5AF5D
`define FG_CAP_DIV          41'h0000FFAE8C

// ***************************************************************
// timing
// ***************************************************************
`define FG_CLK_KHZ          50000
`define FG_T_PERIOD_MS      880
`define FG_T_PRE_US         1000

`endif

// File: hw/fg_measure.sv
// measurement sequencer, result registers, charge accumulator and relative capacity
// Functional notes
// - voltage result refreshed every 880ms, negative readings stored as 0000h, 1.22mV per count.
// - voltage above full scale reads 7FFFh, never wraps.
// - every 1024th conversion measures offset; voltage keeps its previous value.
// - aux conversions alternate inputs, each refreshed every 1760ms into own register.
// - divider supply switched on before each aux input conversion.
// - temperature result refreshed every 1760ms, 0.125 degC per count.
// - temperature select swaps the second aux slot for the on-die sensor.
// - current positive when sense input below ground, negative above.
// - current result refreshed every 880ms at conversion end, 1.5625uV per count.
// - current saturates at 7FFFh for charge and 8000h for discharge.
// - offset slot takes no current sample; current keeps its previous value.
// - bias added to every raw current sample; sum shown and accumulated.
// - bias is readable, writable, two's complement, resets to 00h, applies next sample.
// - accumulator adds each unblanked biased current at its conversion end, span 204.8mVh.
// - relative capacity in 0.5% steps, clamped between 0% and 100%.
// - capacity recomputed after every current conversion and open-circuit update.
// - capacity is last open-circuit capacity plus accumulator times active scale.
// - scaling factors unsigned, 78.125%/Vh per count.
// - learned scale is zero at power-up, overwritten at every learn.
// - current below blanking threshold leaves accumulator unchanged.
// - conversions start only in active mode; one under way when sleep begins still stores its result.
// - divider supply stays off when temperature occupies the second aux slot.
// - reading a result upper byte freezes the pair until the read ends.
`include "fg_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module fg_measure
   import fg_pkg::*;
#(
   parameter int ADC_W = 20,
   parameter int PERIOD_CYC = `FG_T_PERIOD_MS * `FG_CLK_KHZ,
   parameter int SETTLE_CYC = (`FG_T_PRE_US * `FG_CLK_KHZ + 999) / 1000
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic activeMode,
   input wire logic adcDone,
   input wire logic signed [ADC_W-1:0] adcResult,
   input wire logic [7:0] blankThreshold,
   input wire logic ocvUpdate,
   input wire logic [7:0] ocvCapacity,
   input wire logic learnUpdate,
   input wire logic [7:0] learnValue,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic regReadEnd,
   output fg_chan_t convChannel,
   output logic convStart,
   output logic dividerSupplyOn,
   output logic [7:0] regRdData
);
   localparam int SW = ADC_W + 2;

   // ***************************************************************
   // state
   // ***************************************************************
   fg_state_t state;
   fg_step_t step;
   logic [31:0] periodCnt;
   logic [31:0] settleCnt;
   logic [9:0] convCount;
   logic offsetSlot;
   logic auxSel;
   logic signed [ADC_W-1:0] offsetCorr;
   logic [15:0] voltage, aux0, aux1, temperature, current;
   logic [7:0] currentBias, initialScale, learnedScale, lastOcv, relCap;
   logic learnedValid, tempSelect, capReq;
   logic signed [31:0] accumulator;
   logic snapValid;
   logic [7:0] snapAddr, snapData;

   // ***************************************************************
   // arithmetic
   // ***************************************************************
   function automatic logic [15:0] sat16(input logic signed [SW-1:0] v);
      if (v > SW'(32'sh7FFF)) begin
         return `FG_RES_POS_MAX;
      end else if (v < -SW'(32'sh8000)) begin
         return `FG_RES_NEG_MAX;
      end else begin
         return v[15:0];
      end
   endfunction

   function automatic logic [7:0] readByte(input logic [7:0] a);
      case (a)
         `FG_OFS_CONFIG: return {7'h00, tempSelect};
         `FG_OFS_REL_CAP: return relCap;
         `FG_OFS_AUX0: return aux0[15:8];
         `FG_OFS_AUX0 + 8'h01: return aux0[7:0];
         `FG_OFS_AUX1: return aux1[15:8];
         `FG_OFS_AUX1 + 8'h01: return aux1[7:0];
         `FG_OFS_VOLT: return voltage[15:8];
         `FG_OFS_VOLT + 8'h01: return voltage[7:0];
         `FG_OFS_CURR: return current[15:8];
         `FG_OFS_CURR + 8'h01: return current[7:0];
         `FG_OFS_TEMP: return temperature[15:8];
         `FG_OFS_TEMP + 8'h01: return temperature[7:0];
         `FG_OFS_LAST_OPEN_CIRCUIT_CAPACITY: return lastOcv;
         `FG_OFS_LEARN_SCALE: return learnedScale;
         `FG_OFS_BIAS: return currentBias;
         `FG_OFS_INIT_SCALE: return initialScale;
         default: return 8'h00;
      endcase
   endfunction

   logic signed [SW-1:0] corrected, curBiased;
   logic [15:0] curSat;
   logic [16:0] curMag;
   logic blanked;
   logic signed [32:0] accSum;
   logic signed [31:0] next_accumulator;
   logic signed [40:0] capProduct, capQuot;
   logic signed [41:0] capSum;
   logic [7:0] next_relCap;
   logic auxNeedsDivider;

   always_comb begin
      corrected = SW'(adcResult) - SW'(offsetCorr);
      // sense below ground is charge, so the differential reading is negated
      curBiased = -corrected + SW'(signed'({currentBias, 4'h0}));
      curSat = sat16(curBiased);
      curMag = curSat[15] ? 17'h00000 - {1'b1, curSat} : {1'b0, curSat};
      blanked = curMag < {5'h00, blankThreshold, 4'h0};
      accSum = 33'(accumulator) + 33'(signed'(curSat));
      if (accSum > $signed(33'(`FG_ACC_LIMIT))) begin
         next_accumulator = `FG_ACC_LIMIT;
      end else if (accSum < -$signed(33'(`FG_ACC_LIMIT))) begin
         next_accumulator = -`FG_ACC_LIMIT;
      end else begin
         next_accumulator = accSum[31:0];
      end
      capProduct = 41'(accumulator) * 41'($signed({1'b0, learnedValid ? learnedScale : initialScale}));
      capQuot = capProduct / $signed(`FG_CAP_DIV);
      capSum = 42'(capQuot) + 42'($signed({1'b0, lastOcv}));
      if (capSum < 42'sh0) begin
         next_relCap = 8'h00;
      end else if (capSum > 42'(`FG_REL_CAP_MAX)) begin
         next_relCap = `FG_REL_CAP_MAX;
      end else begin
         next_relCap = capSum[7:0];
      end
      auxNeedsDivider = (convCount != `FG_OFFSET_SLOT) && !(auxSel && tempSelect);
   end

   // ***************************************************************
   // conversion period timer
   // ***************************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         periodCnt <= 32'h00000000;
      end else if (activeMode) begin
         if (state == ST_IDLE && periodCnt == 32'h00000000) begin
            periodCnt <= 32'(PERIOD_CYC - 1);
         end else if (periodCnt != 32'h00000000) begin
            periodCnt <= periodCnt - 32'h00000001;
         end
      end
   end

   // ***************************************************************
   // sequencer
   // ***************************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         step <= STEP_VOLT;
         settleCnt <= 32'h00000000;
         convCount <= 10'h000;
         offsetSlot <= 1'b0;
         auxSel <= 1'b0;
         convStart <= 1'b0;
         convChannel <= CH_VOLT;
         dividerSupplyOn <= 1'b0;
      end else begin
         convStart <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (activeMode && periodCnt == 32'h00000000) begin
                  step <= STEP_VOLT;
                  state <= ST_START;
               end
            end
            ST_SETTLE: begin
               if (settleCnt == 32'h00000000) begin
                  state <= ST_START;
               end else begin
                  settleCnt <= settleCnt - 32'h00000001;
               end
            end
            ST_START: begin
               if (!activeMode) begin
                  state <= ST_IDLE;
                  dividerSupplyOn <= 1'b0;
               end else begin
                  convStart <= 1'b1;
                  convCount <= convCount + 10'h001;
                  offsetSlot <= convCount == `FG_OFFSET_SLOT;
                  if (convCount == `FG_OFFSET_SLOT) begin
                     convChannel <= CH_OFFSET;
                  end else if (step == STEP_VOLT) begin
                     convChannel <= CH_VOLT;
                  end else if (step == STEP_CUR) begin
                     convChannel <= CH_CUR;
                  end else if (!auxSel) begin
                     convChannel <= CH_AUX0;
                  end else begin
                     convChannel <= tempSelect ? CH_TEMP : CH_AUX1;
                  end
                  state <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (adcDone) begin
                  case (step)
                     STEP_VOLT: begin
                        step <= STEP_AUX;
                        if (auxNeedsDivider) begin
                           dividerSupplyOn <= 1'b1;
                           settleCnt <= 32'(SETTLE_CYC - 1);
                           state <= ST_SETTLE;
                        end else begin
                           state <= ST_START;
                        end
                     end
                     STEP_AUX: begin
                        step <= STEP_CUR;
                        auxSel <= !auxSel;
                        dividerSupplyOn <= 1'b0;
                        state <= ST_START;
                     end
                     default: begin
                        step <= STEP_VOLT;
                        state <= ST_IDLE;
                     end
                  endcase
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // ***************************************************************
   // result registers
   // ***************************************************************
   logic storeNow;
   assign storeNow = state == ST_WAIT && adcDone;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         offsetCorr <= '0;
         voltage <= 16'h0000;
         aux0 <= 16'h0000;
         aux1 <= 16'h0000;
         temperature <= 16'h0000;
         current <= 16'h0000;
      end else if (storeNow) begin
         // results hold through the offset slot; only the correction moves
         case (convChannel)
            CH_OFFSET: offsetCorr <= adcResult;
            CH_VOLT: voltage <= corrected[SW-1] ? 16'h0000 : sat16(corrected);
            CH_AUX0: aux0 <= sat16(corrected);
            CH_AUX1: aux1 <= sat16(corrected);
            CH_TEMP: temperature <= sat16(corrected);
            CH_CUR: current <= curSat;
            default: voltage <= voltage;
         endcase
      end
   end

   // ***************************************************************
   // accumulator and capacity
   // ***************************************************************
   logic curStore;
   assign curStore = storeNow && convChannel == CH_CUR;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         accumulator <= 32'sh00000000;
         lastOcv <= `FG_LAST_OPEN_CIRCUIT_CAPACITY_RST;
      end else if (ocvUpdate) begin
         // the count restarts from each open-circuit point
         accumulator <= 32'sh00000000;
         lastOcv <= ocvCapacity;
      end else if (curStore && !blanked) begin
         accumulator <= next_accumulator;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         capReq <= 1'b0;
         relCap <= 8'h00;
      end else begin
         capReq <= curStore || ocvUpdate;
         if (capReq) begin
            relCap <= next_relCap;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         learnedScale <= `FG_LEARN_SCALE_RST;
         learnedValid <= 1'b0;
      end else if (learnUpdate) begin
         learnedScale <= learnValue;
         learnedValid <= 1'b1;
      end
   end

   // ***************************************************************
   // register port
   // ***************************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         currentBias <= `FG_BIAS_RST;
         initialScale <= `FG_INIT_SCALE_RST;
         tempSelect <= 1'b0;
      end else if (regWrite) begin
         case (regAddr)
            `FG_OFS_BIAS: currentBias <= regWrData;
            `FG_OFS_INIT_SCALE: initialScale <= regWrData;
            `FG_OFS_CONFIG: tempSelect <= regWrData[`FG_CFG_TEMP_SEL_BIT];
            default: tempSelect <= tempSelect;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         snapValid <= 1'b0;
         snapAddr <= 8'h00;
         snapData <= 8'h00;
         regRdData <= 8'h00;
      end else begin
         if (regReadEnd) begin
            snapValid <= 1'b0;
         end else if (regRead && regAddr >= `FG_OFS_AUX0 && regAddr <= `FG_OFS_TEMP && !regAddr[0]) begin
            snapValid <= 1'b1;
            snapAddr <= regAddr | 8'h01;
            snapData <= readByte(regAddr | 8'h01);
         end
         if (regRead) begin
            regRdData <= (snapValid && regAddr == snapAddr) ? snapData : readByte(regAddr);
         end
      end
   end

   // ***************************************************************
   // checks
   // ***************************************************************
   temp_no_divider_a: assert property (@(posedge clk) disable iff (!rst_n)
      convStart && convChannel == CH_TEMP |-> !dividerSupplyOn) else $error("divider on in temperature slot");
   aux_divider_on_a: assert property (@(posedge clk) disable iff (!rst_n)
      convStart && (convChannel == CH_AUX0 || convChannel == CH_AUX1) |-> dividerSupplyOn)
      else $error("aux conversion without divider supply");
   offset_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      storeNow && convChannel == CH_OFFSET |=> $stable(voltage) && $stable(current))
      else $error("result changed in offset slot");
   blank_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      curStore && blanked && !ocvUpdate |=> $stable(accumulator)) else $error("blanked sample accumulated");
   acc_span_a: assert property (@(posedge clk) disable iff (!rst_n)
      accumulator <= $signed(`FG_ACC_LIMIT) && accumulator >= -$signed(`FG_ACC_LIMIT))
      else $error("accumulator out of span");
   relcap_range_a: assert property (@(posedge clk) disable iff (!rst_n)
      relCap <= `FG_REL_CAP_MAX) else $error("relative capacity above full");
   relcap_update_a: assert property (@(posedge clk) disable iff (!rst_n)
      curStore ##1 !ocvUpdate |=> relCap == $past(next_relCap)) else $error("capacity not recomputed");
   sleep_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
      !activeMode |=> !convStart) else $error("conversion started in sleep");
   learn_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
      !learnedValid |-> learnedScale == 8'h00) else $error("learned scale not zero before learn");
endmodule

`default_nettype wire

// File: hw/fg_pkg.sv
// types shared by the gauge measurement logic
package fg_pkg;
   typedef enum logic [2:0] {CH_VOLT, CH_AUX0, CH_AUX1, CH_TEMP, CH_CUR, CH_OFFSET} fg_chan_t;
   typedef enum logic [1:0] {ST_IDLE, ST_SETTLE, ST_START, ST_WAIT} fg_state_t;
   typedef enum logic [1:0] {STEP_VOLT, STEP_AUX, STEP_CUR} fg_step_t;
endpackage

// File: verification/fg_cell_model.sv
// converter and cell stand-in that answers conversion requests with set levels
`timescale 1ns/1ns
`default_nettype none
module fg_cell_model
   import fg_pkg::*;
(
   input wire logic clk,
   input wire logic convStart,
   input wire fg_chan_t convChannel,
   input wire logic signed [19:0] voltIn,
   input wire logic signed [19:0] aux0In,
   input wire logic signed [19:0] aux1In,
   input wire logic signed [19:0] tempIn,
   input wire logic signed [19:0] curIn,
   output logic adcDone,
   output logic signed [19:0] adcResult
);
   logic slow;
   initial begin
      adcDone = 1'b0;
      adcResult = 20'h00000;
      slow = 1'b0;
      forever begin
         @(posedge clk);
         if (convStart === 1'b1) begin
            // alternate prompt and slow answers
            slow = ~slow;
            repeat (slow ? 9 : 1) @(posedge clk);
            adcDone <= 1'b1;
            case (convChannel)
               CH_VOLT: adcResult <= voltIn;
               CH_AUX0: adcResult <= aux0In;
               CH_AUX1: adcResult <= aux1In;
               CH_TEMP: adcResult <= tempIn;
               CH_CUR: adcResult <= curIn;
               default: adcResult <= 20'h00000;
            endcase
            @(posedge clk);
            adcDone <= 1'b0;
            // result lines no longer valid: show a changed value
            adcResult <= ~adcResult;
         end
      end
   end
endmodule
`default_nettype wire

// File: verification/fuel_gauge_measure_and_capacity_bench.sv
// self-checking bench for the gauge measurement and capacity logic
`timescale 1ns/1ns
`default_nettype none
module fuel_gauge_measure_and_capacity_bench
   import fg_pkg::*;
;
   logic clk, rst_n, activeMode, adcDone, ocvUpdate, learnUpdate, regWrite, regRead, regReadEnd;
   logic convStart, dividerSupplyOn, tempSel;
   logic signed [19:0] adcResult, voltIn, aux0In, aux1In, tempIn, curIn;
   logic [7:0] blankThreshold, ocvCapacity, learnValue, regAddr, regWrData, regRdData;
   fg_chan_t convChannel;
   int n_mismatch, n_checks, seed, curStores;

   fg_measure #(.ADC_W(20), .PERIOD_CYC(200), .SETTLE_CYC(4)) u_dut (.clk(clk), .rst_n(rst_n),
      .activeMode(activeMode), .adcDone(adcDone), .adcResult(adcResult), .blankThreshold(blankThreshold),
      .ocvUpdate(ocvUpdate), .ocvCapacity(ocvCapacity), .learnUpdate(learnUpdate), .learnValue(learnValue),
      .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
      .regReadEnd(regReadEnd), .convChannel(convChannel), .convStart(convStart),
      .dividerSupplyOn(dividerSupplyOn), .regRdData(regRdData));
   fg_cell_model u_cell (.clk(clk), .convStart(convStart), .convChannel(convChannel), .voltIn(voltIn),
      .aux0In(aux0In), .aux1In(aux1In), .tempIn(tempIn), .curIn(curIn), .adcDone(adcDone),
      .adcResult(adcResult));

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic end_of_test;
      if (n_mismatch == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      #1 d = regRdData;
   endtask
   task automatic rd16(input logic [7:0] a, output logic [15:0] d);
      rd(a, d[15:8]);
      rd(a + 8'h01, d[7:0]);
      @(posedge clk);
      regReadEnd <= 1'b1;
      @(posedge clk);
      regReadEnd <= 1'b0;
   endtask
   task automatic wait_stores(input int k);
      int base;
      int t;
      base = curStores;
      t = 0;
      while (curStores < base + k && t < 5000) begin
         @(posedge clk);
         t++;
      end
      if (t >= 5000)
         chk("current store wait", 16'h0001, 16'h0000);
   endtask
   function automatic logic [15:0] sat16(input longint v);
      if (v > 32767)
         return 16'h7FFF;
      if (v < -32768)
         return 16'h8000;
      return v[15:0];
   endfunction
   function automatic logic [15:0] cap_exp(input longint open_circuit_voltage, input longint cur, input longint scale);
      longint r;
      r = open_circuit_voltage + (8 * cur * scale) / 16756364;
      return (r < 0) ? 16'h0000 : (r > 200) ? 16'h00C8 : r[15:0];
   endfunction

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // divider drive and slot use, seen at every conversion start
   always @(posedge clk) begin
      if (adcDone === 1'b1 && convChannel === CH_CUR)
         curStores <= curStores + 1;
      if (convStart === 1'b1) begin
         if (convChannel === CH_AUX0 || convChannel === CH_AUX1)
            chk("divider on at aux start", 16'h0001, {15'h0, dividerSupplyOn});
         if (convChannel === CH_TEMP)
            chk("divider on at temp start", 16'h0000, {15'h0, dividerSupplyOn});
         chk("aux one slot under temp select", 16'h0000, {15'h0, tempSel && convChannel === CH_AUX1});
      end
   end
   initial begin
      #(20 * 40000);
      n_mismatch++;
      end_of_test();
   end

   initial begin
      logic [7:0] d, bias, open_circuit_voltage;
      logic [15:0] w, aux1Old, voltOld;
      longint v, raw;
      {rst_n, activeMode, ocvUpdate, learnUpdate, regWrite, regRead, regReadEnd, tempSel} = 8'h00;
      {blankThreshold, ocvCapacity, learnValue, regAddr, regWrData} = 40'h0;
      {voltIn, aux0In, aux1In, tempIn, curIn} = 100'h0;
      n_mismatch = 0;
      n_checks = 0;
      curStores = 0;
      seed = 25576;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         rd(i == 0 ? 8'h17 : i == 1 ? 8'h33 : i == 2 ? 8'h7A : i == 3 ? 8'h02 : 8'h05, d);
         chk("reset or unmapped read", 16'h0000, {8'h00, d});
      end
      wr(8'h7A, 8'hFF);
      rd(8'h7A, d);
      chk("initial scale", 16'h00FF, {8'h00, d});
      activeMode <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         bias = $random(seed);
         wr(8'h33, bias);
         rd(8'h33, d);
         chk("bias", {8'h00, bias}, {8'h00, d});
         v = (i == 0) ? -5 : (i == 1) ? 40000 : {$random(seed)} % 4096;
         raw = (i == 0) ? -40000 : (i == 1) ? 40000 : $random(seed) % 20000;
         voltIn <= v[19:0];
         curIn <= raw[19:0];
         aux0In <= $random(seed) % 2000;
         aux1In <= $random(seed) % 2000;
         wait_stores(3);
         rd16(8'h0C, w);
         chk("voltage", sat16(v < 0 ? 0 : v), w);
         rd16(8'h0E, w);
         chk("current", sat16(-raw + 16 * $signed(bias)), w);
         rd16(8'h08, w);
         chk("aux zero", aux0In[15:0], w);
         rd16(8'h0A, w);
         chk("aux one", aux1In[15:0], w);
      end
      aux1Old = aux1In[15:0];
      voltOld = sat16(v < 0 ? 0 : v);
      wr(8'h01, 8'h01);
      tempSel = 1'b1;
      tempIn <= $random(seed) % 2000;
      aux1In <= ~aux1In;
      wait_stores(3);
      rd16(8'h10, w);
      chk("temperature", tempIn[15:0], w);
      rd16(8'h0A, w);
      chk("aux one under temp select", aux1Old, w);
      activeMode <= 1'b0;
      voltIn <= 20'h00123;
      repeat (600) @(posedge clk);
      rd16(8'h0C, w);
      chk("voltage held in sleep", voltOld, w);
      wr(8'h33, 8'h00);
      for (int c = 0; c < 4; c++) begin
         if (c == 3) begin
            @(posedge clk);
            learnValue <= 8'h80;
            learnUpdate <= 1'b1;
            @(posedge clk);
            learnUpdate <= 1'b0;
            wr(8'h17, 8'h55);
            rd(8'h17, d);
            chk("learned scale", 16'h0080, {8'h00, d});
         end
         open_circuit_voltage = (c == 1) ? 8'hC6 : (c == 2) ? 8'h02 : {$random(seed)} % 150;
         raw = (c == 2) ? 40000 : -40000;
         @(posedge clk);
         ocvUpdate <= 1'b1;
         ocvCapacity <= open_circuit_voltage;
         curIn <= raw[19:0];
         @(posedge clk);
         ocvUpdate <= 1'b0;
         rd(8'h16, d);
         chk("last open circuit capacity", {8'h00, open_circuit_voltage}, {8'h00, d});
         activeMode <= 1'b1;
         wait_stores(8);
         activeMode <= 1'b0;
         repeat (20) @(posedge clk);
         rd(8'h02, d);
         // charge case from C6h pushes past full, discharge case from 02h past empty
         chk("relative capacity", cap_exp(open_circuit_voltage, sat16(-raw) == 16'h8000 ? -32768 : 32767,
            c == 3 ? 128 : 255), {8'h00, d});
      end
      end_of_test();
   end
endmodule
`default_nettype wire
